// ==== logic/pio_cfg.svh ====
`ifndef PIO_CFG_SVH
`define PIO_CFG_SVH

// register byte offsets
`define PIO_OFS_CTRL 8'h00
`define PIO_OFS_RATE 8'h04
`define PIO_OFS_SCALE 8'h08
`define PIO_OFS_OFFSET 8'h0C
`define PIO_OFS_STATUS 8'h10

// control bit positions
`define PIO_CTRL_ADVANCE 0
`define PIO_CTRL_RETARD 1
`define PIO_CTRL_CLEAR 2

// status bit positions
`define PIO_STAT_ACTIVE 0
`define PIO_STAT_LOOP 1
`define PIO_STAT_CLVM 2

// inch speed in units of 0.0001 rev/s
`define PIO_RATE_RESET 19'h0_03E8
`define PIO_RATE_MIN 19'h0_0001
`define PIO_RATE_MAX 19'h4_93E0

// speed gain in units of 0.001
`define PIO_SCALE_RESET 15'h03E8
`define PIO_SCALE_MIN 15'h0001
`define PIO_SCALE_MAX 15'h7530

// offset is signed, 24 fraction bits, 1.0 = one load revolution
`define PIO_FRAC_BITS 24

// timing
`define PIO_CLK_PERIOD_NS 25
`define PIO_TICK_PERIOD_NS 1000000
// 1e7 (rate x gain units per rev/s) times 1e9 (ns per s)
`define PIO_RATE_TIME_PRODUCT 64'h0023_86F2_6FC1_0000

`endif

// ==== logic/pio_pkg.sv ====
package pio_pkg;

   typedef enum logic [2:0] {
      PIO_IDLE = 3'b001,
      PIO_DIVIDE = 3'b010,
      PIO_APPLY = 3'b100
   } pio_state_t;

   typedef enum logic [1:0] {
      PIO_DIR_NONE = 2'b00,
      PIO_DIR_FWD = 2'b01,
      PIO_DIR_BACK = 2'b10
   } pio_dir_t;

   typedef enum logic [1:0] {
      PIO_RESP_OKAY = 2'b00,
      PIO_RESP_SLVERR = 2'b10
   } pio_resp_t;

endpackage : pio_pkg

// ==== logic/pio_divider.sv ====
`timescale 1ns/1ps

// serial restoring divider, one quotient bit per clock
module pio_divider #(
   parameter int WIDTH = 60
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic start,
   input wire logic [WIDTH-1:0] dividend,
   input wire logic [WIDTH-1:0] divisor,
   output logic [WIDTH-1:0] quotient,
   output logic [WIDTH-1:0] remainder,
   output logic done
);

   logic [7:0] count;
   logic busy;
   logic [WIDTH:0] shifted;

   if (WIDTH < 2 || WIDTH > 200) begin : g_width_check
      $error("pio_divider: WIDTH out of range");
   end

   always_comb begin
      shifted = {remainder, quotient[WIDTH-1]};
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         quotient <= '0;
         remainder <= '0;
         count <= 8'h00;
         busy <= 1'b0;
         done <= 1'b0;
      end else begin
         done <= 1'b0;
         if (start) begin
            quotient <= dividend;
            remainder <= '0;
            count <= 8'(WIDTH);
            busy <= 1'b1;
         end else if (busy) begin
            if (shifted >= {1'b0, divisor}) begin
               remainder <= WIDTH'(shifted - {1'b0, divisor});
               quotient <= {quotient[WIDTH-2:0], 1'b1};
            end else begin
               remainder <= shifted[WIDTH-1:0];
               quotient <= {quotient[WIDTH-2:0], 1'b0};
            end
            count <= count - 8'h01;
            if (count == 8'h01) begin
               busy <= 1'b0;
               done <= 1'b1;
            end
         end
      end
   end

endmodule : pio_divider

// ==== logic/pio_inch_offset.sv ====
// Decided for this implementation: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ps
`include "pio_cfg.svh"

module pio_inch_offset #(
   parameter int TICK_NS = `PIO_TICK_PERIOD_NS,
   parameter int ADDR_W = 8
) (
   input wire logic CLK,
   input wire logic RST,
   input wire logic CLOSED_LOOP_VECTOR_MODE,
   input wire logic POS_LOOP_ACTIVE,
   input wire logic [ADDR_W-1:0] S_AXI_AWADDR,
   input wire logic [2:0] S_AXI_AWPROT,
   input wire logic S_AXI_AWVALID,
   output logic S_AXI_AWREADY,
   input wire logic [31:0] S_AXI_WDATA,
   input wire logic [3:0] S_AXI_WSTRB,
   input wire logic S_AXI_WVALID,
   output logic S_AXI_WREADY,
   output logic [1:0] S_AXI_BRESP,
   output logic S_AXI_BVALID,
   input wire logic S_AXI_BREADY,
   input wire logic [ADDR_W-1:0] S_AXI_ARADDR,
   input wire logic [2:0] S_AXI_ARPROT,
   input wire logic S_AXI_ARVALID,
   output logic S_AXI_ARREADY,
   output logic [31:0] S_AXI_RDATA,
   output logic [1:0] S_AXI_RRESP,
   output logic S_AXI_RVALID,
   input wire logic S_AXI_RREADY,
   output logic [31:0] INCH_OFFSET,
   output logic [31:0] INCH_STEP,
   output logic INCH_STEP_VALID,
   output logic INCH_ACTIVE
);

   localparam int DIV_W = 60;
   localparam int TICK_CYCLES = TICK_NS / `PIO_CLK_PERIOD_NS;
   localparam logic [DIV_W-1:0] DIVISOR = DIV_W'(`PIO_RATE_TIME_PRODUCT / 64'(TICK_NS));

   if (TICK_CYCLES < DIV_W + 8 || TICK_NS > 1000000000 || DIVISOR == '0) begin : g_tick_check
      $error("pio_inch_offset: TICK_NS cannot be served");
   end
   if (ADDR_W < 5 || ADDR_W > 32) begin : g_addr_check
      $error("pio_inch_offset: ADDR_W out of range");
   end

   // registers
   logic cmd_advance;
   logic cmd_retard;
   logic cmd_clear;
   logic [18:0] rate;
   logic [14:0] scale;
   logic signed [31:0] offset;
   logic [DIV_W-1:0] residue;

   // bus slave state
   logic aw_held;
   logic w_held;
   logic [ADDR_W-1:0] aw_addr;
   logic [31:0] w_data;
   logic [3:0] w_strb;

   // inching engine
   pio_pkg::pio_state_t state;
   pio_pkg::pio_dir_t dir;
   pio_pkg::pio_dir_t last_dir;
   logic [31:0] tick_count;
   logic tick;
   logic clearing;
   logic inch_ok;
   pio_pkg::pio_dir_t next_dir;
   logic div_start;
   logic div_done;
   logic [DIV_W-1:0] quotient;
   logic [DIV_W-1:0] remainder;
   logic [DIV_W-1:0] dividend;
   logic [33:0] product;
   logic [31:0] step_mag;
   logic signed [63:0] wide_sum;
   logic signed [31:0] next_offset;

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data,
                                         input logic [3:0] strb);
      logic [31:0] res;
      res = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            res[8*i +: 8] = data[8*i +: 8];
         end
      end
      return res;
   endfunction : merge

   // ---------------- AXI4-Lite write path ----------------
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         aw_addr <= '0;
         w_data <= 32'h0000_0000;
         w_strb <= 4'h0;
         S_AXI_AWREADY <= 1'b1;
         S_AXI_WREADY <= 1'b1;
         S_AXI_BVALID <= 1'b0;
         S_AXI_BRESP <= pio_pkg::PIO_RESP_OKAY;
      end else begin
         if (S_AXI_AWVALID && S_AXI_AWREADY) begin
            aw_held <= 1'b1;
            aw_addr <= S_AXI_AWADDR;
            S_AXI_AWREADY <= 1'b0;
         end
         if (S_AXI_WVALID && S_AXI_WREADY) begin
            w_held <= 1'b1;
            w_data <= S_AXI_WDATA;
            w_strb <= S_AXI_WSTRB;
            S_AXI_WREADY <= 1'b0;
         end
         if (aw_held && w_held && !S_AXI_BVALID) begin
            S_AXI_BVALID <= 1'b1;
            case (aw_addr)
               ADDR_W'(`PIO_OFS_CTRL), ADDR_W'(`PIO_OFS_RATE), ADDR_W'(`PIO_OFS_SCALE),
               ADDR_W'(`PIO_OFS_OFFSET), ADDR_W'(`PIO_OFS_STATUS): S_AXI_BRESP <= pio_pkg::PIO_RESP_OKAY;
               default: S_AXI_BRESP <= pio_pkg::PIO_RESP_SLVERR;
            endcase
         end
         if (S_AXI_BVALID && S_AXI_BREADY) begin
            S_AXI_BVALID <= 1'b0;
            aw_held <= 1'b0;
            w_held <= 1'b0;
            S_AXI_AWREADY <= 1'b1;
            S_AXI_WREADY <= 1'b1;
         end
      end
   end

   // register writes land in the cycle the response is raised
   always_ff @(posedge CLK or posedge RST) begin
      logic [31:0] val;
      if (RST) begin
         cmd_advance <= 1'b0;
         cmd_retard <= 1'b0;
         cmd_clear <= 1'b0;
         rate <= `PIO_RATE_RESET;
         scale <= `PIO_SCALE_RESET;
      end else if (aw_held && w_held && !S_AXI_BVALID) begin
         case (aw_addr)
            ADDR_W'(`PIO_OFS_CTRL): begin
               val = merge({29'h0, cmd_clear, cmd_retard, cmd_advance}, w_data, w_strb);
               cmd_advance <= val[`PIO_CTRL_ADVANCE];
               cmd_retard <= val[`PIO_CTRL_RETARD];
               cmd_clear <= val[`PIO_CTRL_CLEAR];
            end
            ADDR_W'(`PIO_OFS_RATE): begin
               val = merge({13'h0, rate}, w_data, w_strb);
               // out-of-range values clamp instead of being refused
               if (val < 32'(`PIO_RATE_MIN)) begin
                  rate <= `PIO_RATE_MIN;
               end else if (val > 32'(`PIO_RATE_MAX)) begin
                  rate <= `PIO_RATE_MAX;
               end else begin
                  rate <= val[18:0];
               end
            end
            ADDR_W'(`PIO_OFS_SCALE): begin
               val = merge({17'h0, scale}, w_data, w_strb);
               if (val < 32'(`PIO_SCALE_MIN)) begin
                  scale <= `PIO_SCALE_MIN;
               end else if (val > 32'(`PIO_SCALE_MAX)) begin
                  scale <= `PIO_SCALE_MAX;
               end else begin
                  scale <= val[14:0];
               end
            end
            default: begin
               val = 32'h0000_0000;
            end
         endcase
      end
   end

   // ---------------- AXI4-Lite read path ----------------
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         S_AXI_ARREADY <= 1'b1;
         S_AXI_RVALID <= 1'b0;
         S_AXI_RDATA <= 32'h0000_0000;
         S_AXI_RRESP <= pio_pkg::PIO_RESP_OKAY;
      end else begin
         if (S_AXI_ARVALID && S_AXI_ARREADY) begin
            S_AXI_ARREADY <= 1'b0;
            S_AXI_RVALID <= 1'b1;
            S_AXI_RRESP <= pio_pkg::PIO_RESP_OKAY;
            case (S_AXI_ARADDR)
               ADDR_W'(`PIO_OFS_CTRL): S_AXI_RDATA <= {29'h0, cmd_clear, cmd_retard, cmd_advance};
               ADDR_W'(`PIO_OFS_RATE): S_AXI_RDATA <= {13'h0, rate};
               ADDR_W'(`PIO_OFS_SCALE): S_AXI_RDATA <= {17'h0, scale};
               ADDR_W'(`PIO_OFS_OFFSET): S_AXI_RDATA <= offset;
               ADDR_W'(`PIO_OFS_STATUS): S_AXI_RDATA <= {29'h0, CLOSED_LOOP_VECTOR_MODE, POS_LOOP_ACTIVE,
                                                         INCH_ACTIVE};
               default: begin
                  S_AXI_RDATA <= 32'h0000_0000;
                  S_AXI_RRESP <= pio_pkg::PIO_RESP_SLVERR;
               end
            endcase
         end else if (S_AXI_RVALID && S_AXI_RREADY) begin
            S_AXI_RVALID <= 1'b0;
            S_AXI_ARREADY <= 1'b1;
         end
      end
   end

   // ---------------- control tick ----------------
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         tick_count <= 32'h0000_0000;
      end else if (tick) begin
         tick_count <= 32'h0000_0000;
      end else begin
         tick_count <= tick_count + 32'h0000_0001;
      end
   end

   always_comb begin
      tick = (tick_count == 32'(TICK_CYCLES - 1));
      clearing = cmd_clear && !POS_LOOP_ACTIVE;
      inch_ok = CLOSED_LOOP_VECTOR_MODE;
      if (cmd_advance && !cmd_retard) begin
         next_dir = pio_pkg::PIO_DIR_FWD;
      end else if (cmd_retard && !cmd_advance) begin
         next_dir = pio_pkg::PIO_DIR_BACK;
      end else begin
         next_dir = pio_pkg::PIO_DIR_NONE;
      end
      div_start = tick && inch_ok && !clearing && next_dir != pio_pkg::PIO_DIR_NONE
                  && state == pio_pkg::PIO_IDLE;
      product = 34'(rate) * 34'(scale);
      // residue is dropped when direction turns, so it never counts the wrong way
      dividend = DIV_W'({product, {`PIO_FRAC_BITS{1'b0}}})
                 + ((next_dir == last_dir) ? residue : '0);
      step_mag = (|quotient[DIV_W-1:31]) ? 32'h7FFF_FFFF : {1'b0, quotient[30:0]};
      if (dir == pio_pkg::PIO_DIR_BACK) begin
         wide_sum = 64'(offset) - 64'($signed({4'h0, quotient}));
      end else begin
         wide_sum = 64'(offset) + 64'($signed({4'h0, quotient}));
      end
      // saturate rather than wrap: a wrapped offset would jump the load a full range
      if (wide_sum > 64'sh0000_0000_7FFF_FFFF) begin
         next_offset = 32'sh7FFF_FFFF;
      end else if (wide_sum < -64'sh0000_0000_8000_0000) begin
         next_offset = -32'sh8000_0000;
      end else begin
         next_offset = wide_sum[31:0];
      end
   end

   pio_divider #(
      .WIDTH(DIV_W)
   ) u_divider (
      .clk(CLK),
      .rst(RST),
      .start(div_start),
      .dividend(dividend),
      .divisor(DIVISOR),
      .quotient(quotient),
      .remainder(remainder),
      .done(div_done)
   );

   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         state <= pio_pkg::PIO_IDLE;
         dir <= pio_pkg::PIO_DIR_NONE;
         last_dir <= pio_pkg::PIO_DIR_NONE;
      end else if (clearing) begin
         state <= pio_pkg::PIO_IDLE;
         last_dir <= pio_pkg::PIO_DIR_NONE;
      end else begin
         case (state)
            pio_pkg::PIO_IDLE: begin
               if (div_start) begin
                  state <= pio_pkg::PIO_DIVIDE;
                  dir <= next_dir;
                  last_dir <= next_dir;
               end
            end
            pio_pkg::PIO_DIVIDE: begin
               if (div_done) begin
                  state <= pio_pkg::PIO_APPLY;
               end
            end
            pio_pkg::PIO_APPLY: begin
               state <= pio_pkg::PIO_IDLE;
            end
            default: begin
               state <= pio_pkg::PIO_IDLE;
            end
         endcase
      end
   end

   // offset and remainder persist between inch actions
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         offset <= 32'sh0000_0000;
         residue <= '0;
      end else if (clearing) begin
         offset <= 32'sh0000_0000;
         residue <= '0;
      end else if (state == pio_pkg::PIO_APPLY && inch_ok) begin
         offset <= next_offset;
         residue <= remainder;
      end
   end

   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         INCH_OFFSET <= 32'h0000_0000;
         INCH_STEP <= 32'h0000_0000;
         INCH_STEP_VALID <= 1'b0;
         INCH_ACTIVE <= 1'b0;
      end else begin
         INCH_OFFSET <= offset;
         INCH_ACTIVE <= inch_ok && (next_dir != pio_pkg::PIO_DIR_NONE);
         INCH_STEP_VALID <= 1'b0;
         if (state == pio_pkg::PIO_APPLY && !clearing && inch_ok) begin
            INCH_STEP_VALID <= 1'b1;
            INCH_STEP <= (dir == pio_pkg::PIO_DIR_BACK) ? (32'h0000_0000 - step_mag) : step_mag;
         end
      end
   end

endmodule : pio_inch_offset

// ==== verification/pio_inch_offset_asserts.sv ====
`timescale 1ns/1ps
module pio_inch_offset_asserts (
   input wire logic CLK,
   input wire logic RST,
   input wire logic CLOSED_LOOP_VECTOR_MODE,
   input wire logic S_AXI_AWVALID,
   input wire logic S_AXI_AWREADY,
   input wire logic S_AXI_WVALID,
   input wire logic S_AXI_WREADY,
   input wire logic [1:0] S_AXI_BRESP,
   input wire logic S_AXI_BVALID,
   input wire logic S_AXI_BREADY,
   input wire logic S_AXI_ARVALID,
   input wire logic S_AXI_ARREADY,
   input wire logic [31:0] S_AXI_RDATA,
   input wire logic S_AXI_RVALID,
   input wire logic S_AXI_RREADY,
   input wire logic [31:0] INCH_OFFSET,
   input wire logic [31:0] INCH_STEP,
   input wire logic INCH_STEP_VALID,
   input wire logic INCH_ACTIVE
);
   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (RST);
   // cycles since active; a step may trail the command by one divide
   logic [6:0] idle_cnt;
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         idle_cnt <= 7'h7F;
      end else if (INCH_ACTIVE) begin
         idle_cnt <= 7'h00;
      end else if (idle_cnt != 7'h7F) begin
         idle_cnt <= idle_cnt + 7'h01;
      end
   end
   sequence s_wr_taken;
      S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY;
   endsequence
   sequence s_rd_taken;
      S_AXI_ARVALID && S_AXI_ARREADY;
   endsequence
   a_step_one_cycle: assert property (INCH_STEP_VALID |=> !INCH_STEP_VALID)
      else $error("step pulse longer than one cycle");
   a_offset_adds_step: assert property (INCH_STEP_VALID |=> INCH_OFFSET == $past(INCH_OFFSET) + $past(INCH_STEP))
      else $error("offset did not take the step");
   a_offset_persists: assert property ($changed(INCH_OFFSET) |-> $past(INCH_STEP_VALID) || INCH_OFFSET == 32'h0)
      else $error("offset moved without a step");
   a_step_needs_active: assert property (INCH_STEP_VALID |-> idle_cnt < 7'h46)
      else $error("step while not inching");
   a_mode_gates_active: assert property (!CLOSED_LOOP_VECTOR_MODE |=> !INCH_ACTIVE)
      else $error("active outside vector mode");
   a_wr_answer: assert property (s_wr_taken |=> !S_AXI_BVALID && !S_AXI_AWREADY ##1 S_AXI_BVALID)
      else $error("write answer timing wrong");
   a_rd_answer: assert property (s_rd_taken |=> S_AXI_RVALID && !S_AXI_ARREADY)
      else $error("read answer timing wrong");
   a_b_holds: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP))
      else $error("write response dropped early");
   a_r_holds: assert property (S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
      else $error("read data dropped early");
endmodule : pio_inch_offset_asserts
bind pio_inch_offset pio_inch_offset_asserts u_chk (.CLK, .RST, .CLOSED_LOOP_VECTOR_MODE, .S_AXI_AWVALID,
   .S_AXI_AWREADY, .S_AXI_WVALID, .S_AXI_WREADY, .S_AXI_BRESP, .S_AXI_BVALID, .S_AXI_BREADY, .S_AXI_ARVALID,
   .S_AXI_ARREADY, .S_AXI_RDATA, .S_AXI_RVALID, .S_AXI_RREADY, .INCH_OFFSET, .INCH_STEP, .INCH_STEP_VALID,
   .INCH_ACTIVE);

// ==== verification/pio_drive_model.sv ====
`timescale 1ns/1ps
// drive-side levels, registered as a real status path would be
module pio_drive_model (
   input wire logic clk,
   input wire logic want_mode,
   input wire logic want_loop,
   output logic mode = 1'b0,
   output logic loop_active = 1'b0
);
   always @(posedge clk) begin
      mode <= want_mode;
      loop_active <= want_loop;
   end
endmodule : pio_drive_model

// ==== verification/pio_inch_offset_tb_top.sv ====
`timescale 1ns/1ps
`include "pio_cfg.svh"
module pio_inch_offset_tb_top;
   typedef struct {logic [31:0] ctrl; logic md; logic act; int sgn;} pio_row_t;
   logic clk = 1'b0, rst = 1'b1, want_mode = 1'b0, want_loop = 1'b0, mode, loop;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0000_0000, rdata, off, step, last_step = 32'h0000_0000;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic awready, wready, bvalid, arready, rvalid, step_v, act;
   logic [1:0] bresp, rresp;
   int bad_count = 0, n_checks = 0, pulses = 0;
   pio_row_t rows [5] = '{'{32'h0000_0001, 1'b1, 1'b1, 1}, '{32'h0000_0002, 1'b1, 1'b1, -1},
      '{32'h0000_0003, 1'b1, 1'b0, 0}, '{32'h0000_0001, 1'b0, 1'b0, 0}, '{32'h0000_0005, 1'b1, 1'b1, 0}};
   logic [7:0] rst_a [4] = '{`PIO_OFS_CTRL, `PIO_OFS_RATE, `PIO_OFS_SCALE, `PIO_OFS_OFFSET};
   logic [31:0] rst_v [4] = '{32'h0000_0000, 32'h0000_03E8, 32'h0000_03E8, 32'h0000_0000};
   logic [7:0] lim_a [4] = '{`PIO_OFS_RATE, `PIO_OFS_RATE, `PIO_OFS_SCALE, `PIO_OFS_SCALE};
   logic [31:0] lim_w [4] = '{32'h0000_0000, 32'hFFFF_FFFF, 32'h0000_0000, 32'hFFFF_FFFF};
   logic [31:0] lim_v [4] = '{32'h0000_0001, 32'h0004_93E0, 32'h0000_0001, 32'h0000_7530};

   initial begin
      forever #12.5 clk = ~clk;
   end

   pio_drive_model u_drv (.clk(clk), .want_mode(want_mode), .want_loop(want_loop), .mode(mode),
      .loop_active(loop));

   // short tick keeps the run brief: 80 clocks per tick
   pio_inch_offset #(.TICK_NS(2000)) dut (.CLK(clk), .RST(rst), .CLOSED_LOOP_VECTOR_MODE(mode),
      .POS_LOOP_ACTIVE(loop), .S_AXI_AWADDR(awaddr), .S_AXI_AWPROT(3'h0), .S_AXI_AWVALID(awvalid),
      .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wvalid),
      .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
      .S_AXI_ARADDR(araddr), .S_AXI_ARPROT(3'h0), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
      .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
      .INCH_OFFSET(off), .INCH_STEP(step), .INCH_STEP_VALID(step_v), .INCH_ACTIVE(act));

   always @(posedge clk) begin
      if (step_v === 1'b1) begin
         pulses <= pulses + 1;
         last_step <= step;
      end
   end

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk

   // no local limit: only the watchdog ends a wait for the answer
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      @(posedge clk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge clk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (!bvalid);
      r = bresp;
      bready <= 1'b0;
   endtask : axi_wr

   task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge clk);
         if (arready) arvalid <= 1'b0;
      end while (!rvalid);
      d = rdata;
      r = rresp;
      rready <= 1'b0;
   endtask : axi_rd

   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : report_and_stop

   initial begin
      repeat (30000) @(posedge clk);
      bad_count++;
      report_and_stop();
   end

   initial begin
      logic [1:0] r;
      logic [31:0] d, held;
      longint e, e2;
      int base, n;
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      // 25.0000 rev/s times 20.000 gives 16777.216 counts per tick
      axi_wr(`PIO_OFS_RATE, 32'h0003_D090, r);
      axi_wr(`PIO_OFS_SCALE, 32'h0000_4E20, r);
      foreach (rows[i]) begin
         want_mode <= rows[i].md;
         axi_wr(`PIO_OFS_CTRL, 32'h0000_0004, r);
         axi_wr(`PIO_OFS_CTRL, rows[i].ctrl, r);
         base = pulses;
         repeat (400) @(posedge clk);
         chk(act, rows[i].act);
         axi_wr(`PIO_OFS_CTRL, 32'h0000_0000, r);
         repeat (70) @(posedge clk);
         n = pulses - base;
         e = rows[i].sgn * ((n * 64'd16777216) / 1000);
         chk(off, e[31:0]);
         chk(n != 0, rows[i].sgn != 0);
         // last step is the growth of the floored running total, residue carried
         if (n != 0) begin
            e2 = rows[i].sgn * (((n - 1) * 64'd16777216) / 1000);
            chk(last_step, 32'(e - e2));
         end
         axi_rd(`PIO_OFS_OFFSET, d, r);
         chk(d, e[31:0]);
         $display("row %0d done", i);
      end
      want_mode <= 1'b1;
      axi_wr(`PIO_OFS_CTRL, 32'h0000_0001, r);
      repeat (300) @(posedge clk);
      axi_wr(`PIO_OFS_CTRL, 32'h0000_0000, r);
      repeat (70) @(posedge clk);
      held = off;
      repeat (200) @(posedge clk);
      chk(off, held);
      chk(held != 0, 1);
      // clear attempted with the loop running must wait until the loop stops
      want_loop <= 1'b1;
      axi_wr(`PIO_OFS_CTRL, 32'h0000_0004, r);
      repeat (5) @(posedge clk);
      chk(off, held);
      axi_rd(`PIO_OFS_STATUS, d, r);
      chk(d & 32'h0000_0007, 32'h0000_0006);
      want_loop <= 1'b0;
      repeat (5) @(posedge clk);
      chk(off, 0);
      axi_wr(`PIO_OFS_CTRL, 32'h0000_0000, r);
      $display("clear gating done");
      foreach (lim_a[i]) begin
         axi_wr(lim_a[i], lim_w[i], r);
         axi_rd(lim_a[i], d, r);
         chk(d, lim_v[i]);
      end
      axi_wr(8'h14, 32'h0000_0001, r);
      chk(r, 2);
      axi_rd(8'h14, d, r);
      chk(r, 2);
      chk(d, 0);
      $display("limits and unmapped done");
      axi_wr(`PIO_OFS_CTRL, 32'h0000_0001, r);
      repeat (200) @(posedge clk);
      rst <= 1'b1;
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      chk(act, 0);
      foreach (rst_a[i]) begin
         axi_rd(rst_a[i], d, r);
         chk(d, rst_v[i]);
      end
      $display("reset values done");
      report_and_stop();
   end
endmodule : pio_inch_offset_tb_top
